// ===== pevs_pkg.sv
// constants and state type for the primary event status logic
package pevs_pkg;

    // register offsets on the device register port
    localparam logic [7:0] PEVS_OFF_STATUS  = 8'h41;
    localparam logic [7:0] PEVS_OFF_EN_VOLT = 8'h7E;
    localparam logic [7:0] PEVS_OFF_EN_TEMP = 8'h82;

    // reset values
    localparam logic [7:0] PEVS_RST_STATUS  = 8'h00;
    localparam logic [7:0] PEVS_RST_EN_VOLT = 8'h00;
    localparam logic [7:0] PEVS_RST_EN_TEMP = 8'h00;
    localparam logic [7:0] PEVS_RDATA_NONE  = 8'h00;
    localparam logic [4:0] PEVS_RST_ACTIVE  = 5'h00;

    // monitored channels: 0 core supply, 1 main supply, 2 remote one,
    // 3 internal sensor, 4 remote two
    localparam int unsigned PEVS_NCH = 5;

    // status bit positions
    localparam int unsigned PEVS_BIT_CORE_V  = 1;
    localparam int unsigned PEVS_BIT_MAIN_V  = 2;
    localparam int unsigned PEVS_BIT_REMOTE1 = 4;
    localparam int unsigned PEVS_BIT_INTERN  = 5;
    localparam int unsigned PEVS_BIT_REMOTE2 = 6;
    localparam int unsigned PEVS_BIT_SUMMARY = 7;

    // individual enable bit positions inside the two enable registers
    localparam int unsigned PEVS_EN_CORE_V  = 1;
    localparam int unsigned PEVS_EN_MAIN_V  = 2;
    localparam int unsigned PEVS_EN_REMOTE1 = 0;
    localparam int unsigned PEVS_EN_INTERN  = 1;
    localparam int unsigned PEVS_EN_REMOTE2 = 2;

    // channels whose readings are two's complement temperatures
    localparam logic [4:0] PEVS_TEMP_MASK = 5'h1C;

    typedef struct packed {
        logic [7:0] status;
        logic [4:0] active;
        logic [7:0] en_volt;
        logic [7:0] en_temp;
        logic [7:0] rdata;
    } pevs_state_t;

endpackage

// ===== pevs_status.sv
// primary event status register with sticky, clear-on-read limit flags
//
// Function
// - core supply out of window sets bit 1
// - main supply out of window sets bit 2
// - remote one temperature out of window sets bit 4
// - internal temperature out of window sets bit 5
// - remote two temperature out of window sets bit 6
// - bit 7 set when secondary status nonzero
// - bit 7 clears when secondary status empty
// - flag sets only when enabled and violated
// - flag sticks until read or disabled
// - read clears only flags no longer violating
// - register read only, writes ignored
// - disabled flag never rises
// - disabled set flag clears at next reading update
// - readings update only while monitoring runs
// - group and global enables leave flags alone
// - temperature enables live at offset 82h
// - supply enables live at offset 7Eh
// - no flag sets while monitoring stopped
`timescale 1ns/1ps

module pevs_status (
    // clock and reset
    input  wire logic                clk,
    input  wire logic                nrst,
    // register port
    input  wire logic [7:0]          reg_addr,
    input  wire logic                reg_rd,
    input  wire logic                reg_wr,
    input  wire logic [7:0]          reg_wdata,
    output logic      [7:0]          reg_rdata,
    // measurement engine
    input  wire logic                mon_start,
    input  wire logic [4:0]          reading_upd,
    input  wire logic [4:0][7:0]     reading,
    input  wire logic [4:0][7:0]     limit_low,
    input  wire logic [4:0][7:0]     limit_high,
    // secondary status register contents
    input  wire logic [7:0]          sec_status,
    // state views
    output logic      [7:0]          primary_event_status,
    output logic      [7:0]          volt_irq_enable,
    output logic      [7:0]          temp_irq_enable
);

    localparam int unsigned POS [5] = '{pevs_pkg::PEVS_BIT_CORE_V,
                                        pevs_pkg::PEVS_BIT_MAIN_V,
                                        pevs_pkg::PEVS_BIT_REMOTE1,
                                        pevs_pkg::PEVS_BIT_INTERN,
                                        pevs_pkg::PEVS_BIT_REMOTE2};
    localparam int unsigned ENP [5] = '{pevs_pkg::PEVS_EN_CORE_V,
                                        pevs_pkg::PEVS_EN_MAIN_V,
                                        pevs_pkg::PEVS_EN_REMOTE1,
                                        pevs_pkg::PEVS_EN_INTERN,
                                        pevs_pkg::PEVS_EN_REMOTE2};

    pevs_pkg::pevs_state_t q;
    pevs_pkg::pevs_state_t d;

    logic       rd_hit;
    logic [4:0] en;
    logic [4:0] viol;
    logic [4:0] upd;
    logic [4:0] set_ev;
    logic [4:0] dis_clr;
    logic [4:0] flag_d;
    logic [4:0] act_d;

    assign rd_hit = reg_rd && (reg_addr == pevs_pkg::PEVS_OFF_STATUS);

    genvar i;
    generate
        for (i = 0; i < pevs_pkg::PEVS_NCH; i++) begin : g_ch
            // supplies live in one enable register, temperatures in the other
            if (!pevs_pkg::PEVS_TEMP_MASK[i]) begin : g_v
                assign en[i] = q.en_volt[ENP[i]];
            end else begin : g_t
                assign en[i] = q.en_temp[ENP[i]];
            end
            // temperatures are signed so a forced fault reading trips the low limit
            if (pevs_pkg::PEVS_TEMP_MASK[i]) begin : g_s
                assign viol[i] = ($signed(reading[i]) <= $signed(limit_low[i]))
                               || ($signed(reading[i]) > $signed(limit_high[i]));
            end else begin : g_u
                assign viol[i] = (reading[i] <= limit_low[i])
                               || (reading[i] > limit_high[i]);
            end
            // readings only move while monitoring runs
            assign upd[i]     = reading_upd[i] && mon_start;
            assign set_ev[i]  = upd[i] && en[i] && viol[i];
            assign dis_clr[i] = upd[i] && !en[i];
            // active tracks the last evaluated violation for the read clear
            assign act_d[i] = upd[i] ? (en[i] && viol[i]) : q.active[i];
            // set wins over any clear in the same cycle
            assign flag_d[i] = set_ev[i]
                             || (q.status[POS[i]]
                                 && !(rd_hit && !q.active[i])
                                 && !dis_clr[i]);

            a_set_on_viol: assert property (@(posedge clk) disable iff (!nrst)
                set_ev[i] |=> q.status[POS[i]])
                else $error("flag not set on enabled violation");
            a_no_rise_dis: assert property (@(posedge clk) disable iff (!nrst)
                (!en[i] && !q.status[POS[i]]) |=> !q.status[POS[i]])
                else $error("disabled flag rose");
            a_no_rise_stop: assert property (@(posedge clk) disable iff (!nrst)
                (!mon_start && !q.status[POS[i]]) |=> !q.status[POS[i]])
                else $error("flag rose while monitoring stopped");
            a_disable_clear: assert property (@(posedge clk) disable iff (!nrst)
                dis_clr[i] |=> !q.status[POS[i]])
                else $error("disabled flag not cleared on update");
            a_flag_sticks: assert property (@(posedge clk) disable iff (!nrst)
                (q.status[POS[i]] && !rd_hit && !dis_clr[i]) |=> q.status[POS[i]])
                else $error("flag dropped without read or disable");
            a_read_clears: assert property (@(posedge clk) disable iff (!nrst)
                (rd_hit && !q.active[i] && !set_ev[i]) |=> !q.status[POS[i]])
                else $error("inactive flag survived read");
            a_read_keeps: assert property (@(posedge clk) disable iff (!nrst)
                (rd_hit && q.active[i] && q.status[POS[i]] && !dis_clr[i])
                |=> q.status[POS[i]])
                else $error("active flag cleared by read");
        end
    endgenerate

    always_comb begin
        d = q;
        // group and global bits are stored but never touch the flags
        if (reg_wr && (reg_addr == pevs_pkg::PEVS_OFF_EN_VOLT)) begin
            d.en_volt = reg_wdata;
        end
        if (reg_wr && (reg_addr == pevs_pkg::PEVS_OFF_EN_TEMP)) begin
            d.en_temp = reg_wdata;
        end
        // read data taken from the flags before this cycle's clear
        if (reg_rd) begin
            case (reg_addr)
                pevs_pkg::PEVS_OFF_STATUS:  d.rdata = q.status;
                pevs_pkg::PEVS_OFF_EN_VOLT: d.rdata = q.en_volt;
                pevs_pkg::PEVS_OFF_EN_TEMP: d.rdata = q.en_temp;
                default:                    d.rdata = pevs_pkg::PEVS_RDATA_NONE;
            endcase
        end
        // status has no write path at all
        d.status = pevs_pkg::PEVS_RST_STATUS;
        d.status[pevs_pkg::PEVS_BIT_SUMMARY] = |sec_status;
        for (int k = 0; k < pevs_pkg::PEVS_NCH; k++) begin
            d.status[POS[k]] = flag_d[k];
        end
        d.active = act_d;
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            q.status  <= pevs_pkg::PEVS_RST_STATUS;
            q.active  <= pevs_pkg::PEVS_RST_ACTIVE;
            q.en_volt <= pevs_pkg::PEVS_RST_EN_VOLT;
            q.en_temp <= pevs_pkg::PEVS_RST_EN_TEMP;
            q.rdata   <= pevs_pkg::PEVS_RDATA_NONE;
        end else begin
            q <= d;
        end
    end

    assign reg_rdata            = q.rdata;
    assign primary_event_status = q.status;
    assign volt_irq_enable      = q.en_volt;
    assign temp_irq_enable      = q.en_temp;

    a_summary_mirror: assert property (@(posedge clk) disable iff (!nrst)
        (|sec_status) |=> q.status[pevs_pkg::PEVS_BIT_SUMMARY])
        else $error("summary bit missed secondary status");
    a_summary_clear: assert property (@(posedge clk) disable iff (!nrst)
        !(|sec_status) |=> !q.status[pevs_pkg::PEVS_BIT_SUMMARY])
        else $error("summary bit stuck with secondary empty");
    a_read_data: assert property (@(posedge clk) disable iff (!nrst)
        rd_hit |=> (reg_rdata == $past(q.status)))
        else $error("read data not pre-clear flags");
    a_reserved_zero: assert property (@(posedge clk) disable iff (!nrst)
        (reg_wr && reg_addr == pevs_pkg::PEVS_OFF_STATUS)
        |=> !q.status[0] && !q.status[3])
        else $error("write reached reserved status bits");
    a_group_ignored: assert property (@(posedge clk) disable iff (!nrst)
        (reg_wr && reg_addr == pevs_pkg::PEVS_OFF_EN_TEMP && reading_upd == 5'h00
         && !rd_hit && (|sec_status) == q.status[pevs_pkg::PEVS_BIT_SUMMARY])
        |=> (q.status == $past(q.status)))
        else $error("enable write changed status flags");
    // a write aimed at the status address must leave every flag as it was
    a_status_write: assert property (@(posedge clk) disable iff (!nrst)
        (reg_wr && reg_addr == pevs_pkg::PEVS_OFF_STATUS && reading_upd == 5'h00
         && !rd_hit && (|sec_status) == q.status[pevs_pkg::PEVS_BIT_SUMMARY])
        |=> (q.status == $past(q.status)))
        else $error("status write changed flags");
    a_volt_write: assert property (@(posedge clk) disable iff (!nrst)
        (reg_wr && reg_addr == pevs_pkg::PEVS_OFF_EN_VOLT)
        |=> (volt_irq_enable == $past(reg_wdata)))
        else $error("supply enable write lost");
    a_temp_write: assert property (@(posedge clk) disable iff (!nrst)
        (reg_wr && reg_addr == pevs_pkg::PEVS_OFF_EN_TEMP)
        |=> (temp_irq_enable == $past(reg_wdata)))
        else $error("temperature enable write lost");
    // read data must not drift between reads, software may sample it late
    a_rdata_hold: assert property (@(posedge clk) disable iff (!nrst)
        !reg_rd |=> $stable(reg_rdata))
        else $error("read data changed without a read");

endmodule

// ===== pevs_host.sv
// host model issuing single-byte register reads and writes
`timescale 1ns/1ps
module pevs_host (
    // clock
    input  wire logic       clk,
    // register port
    output logic      [7:0] reg_addr,
    output logic            reg_rd,
    output logic            reg_wr,
    output logic      [7:0] reg_wdata
);
    logic [7:0] exp_q[$];
    initial begin
        reg_addr  = 8'h00;
        reg_rd    = 1'b0;
        reg_wr    = 1'b0;
        reg_wdata = 8'h00;
    end
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        reg_addr  = a;
        reg_wdata = d;
        reg_wr    = 1'b1;
        @(negedge clk);
        reg_wr    = 1'b0;
        reg_wdata = ~d;
    endtask
    // read task queues the expected read data for the testbench checker
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(negedge clk);
        reg_addr = a;
        reg_rd   = 1'b1;
        exp_q.push_back(e);
        @(negedge clk);
        reg_rd   = 1'b0;
        reg_addr = ~a;
    endtask
endmodule

// ===== tb.sv
// self-checking testbench for the primary event status logic
`timescale 1ns/1ps
module tb;
    logic            clk, nrst, mon_start, reg_rd, reg_wr, rd_seen;
    logic [7:0]      reg_addr, reg_wdata, reg_rdata, sec_status, m, ea, iw, pes, ven, ten;
    logic [4:0]      reading_upd;
    logic [4:0][7:0] reading, limit_low, limit_high;
    int              errors, samples_checked, ch;
    logic [7:0]      bmsk[5] = '{8'h02, 8'h04, 8'h10, 8'h20, 8'h40};
    logic [7:0]      eadr[5] = '{8'h7E, 8'h7E, 8'h82, 8'h82, 8'h82};
    logic [7:0]      emsk[5] = '{8'h02, 8'h04, 8'h01, 8'h02, 8'h04};

    pevs_host i_host (.clk(clk), .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_wr(reg_wr),
        .reg_wdata(reg_wdata));
    pevs_status i_dut (.clk(clk), .nrst(nrst), .reg_addr(reg_addr), .reg_rd(reg_rd),
        .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .mon_start(mon_start), .reading_upd(reading_upd), .reading(reading),
        .limit_low(limit_low), .limit_high(limit_high), .sec_status(sec_status),
        .primary_event_status(pes), .volt_irq_enable(ven), .temp_irq_enable(ten));

    initial clk = 1'b0;
    always #4 clk = ~clk;

    task automatic chk(string n, logic [7:0] s, logic [7:0] e);
        samples_checked++;
        if (s !== e) begin
            errors++;
            $display("Error %s expected %h seen %h", n, e, s);
        end
    endtask

    task automatic results;
        chk("pending reads", 8'(i_host.exp_q.size()), 8'h00);
        $display("errors %0d samples_checked %0d", errors, samples_checked);
        if (errors == 0 && samples_checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // read data lands one cycle after the read edge
    always @(posedge clk) begin
        if (rd_seen === 1'b1 && i_host.exp_q.size() > 0) begin
            chk("reg_rdata", reg_rdata, i_host.exp_q.pop_front());
        end
        rd_seen <= reg_rd;
    end

    task automatic upd(input int c, input logic [7:0] v, input logic st);
        @(negedge clk);
        reading[c]     = v;
        reading_upd[c] = 1'b1;
        mon_start      = st;
        @(negedge clk);
        reading_upd    = 5'h00;
    endtask

    initial begin
        repeat (20000) @(posedge clk);
        errors++;
        results;
    end

    initial begin
        nrst = 1'b0;
        mon_start = 1'b1;
        rd_seen = 1'b0;
        reading_upd = 5'h00;
        reading = {5{8'h20}};
        limit_low = {5{8'h10}};
        limit_high = {5{8'h40}};
        sec_status = 8'h00;
        void'($urandom(32'h2694));
        repeat (12) @(negedge clk);
        nrst = 1'b1;
        i_host.rd(8'h41, 8'h00);
        i_host.rd(8'h7E, 8'h00);
        i_host.wr(8'h7E, 8'hFF);
        i_host.wr(8'h82, 8'hFF);
        chk("volt_irq_enable", ven, 8'hFF);
        chk("temp_irq_enable", ten, 8'hFF);
        i_host.rd(8'h7E, 8'hFF);
        i_host.rd(8'h82, 8'hFF);
        i_host.rd(8'h55, 8'h00);
        for (ch = 0; ch < 5; ch++) begin
            m  = bmsk[ch];
            ea = eadr[ch];
            iw = 8'h11 + 8'($urandom % 48);
            upd(ch, 8'h10, 1'b1);
            chk("primary_event_status", pes, m);
            i_host.rd(8'h41, m);
            upd(ch, iw, 1'b1);
            i_host.rd(8'h41, m);
            chk("primary_event_status", pes, 8'h00);
            i_host.rd(8'h41, 8'h00);
            upd(ch, 8'h40, 1'b1);
            i_host.rd(8'h41, 8'h00);
            upd(ch, 8'h41, 1'b1);
            i_host.rd(8'h41, m);
            i_host.rd(8'h41, m);
            i_host.wr(8'h41, 8'hFF);
            i_host.wr(ea, emsk[ch]);
            chk("irq enable view", (ea == 8'h7E) ? ven : ten, emsk[ch]);
            i_host.rd(8'h41, m);
            i_host.rd(ea, emsk[ch]);
            i_host.wr(ea, ~emsk[ch]);
            upd(ch, 8'h41, 1'b0);
            i_host.rd(8'h41, m);
            upd(ch, 8'h41, 1'b1);
            i_host.rd(8'h41, 8'h00);
            upd(ch, 8'h10, 1'b1);
            i_host.rd(8'h41, 8'h00);
            i_host.wr(ea, 8'hFF);
            upd(ch, 8'h10, 1'b0);
            i_host.rd(8'h41, 8'h00);
            upd(ch, iw, 1'b1);
        end
        sec_status = 8'h01 | 8'($urandom);
        i_host.rd(8'h41, 8'h80);
        i_host.rd(8'h41, 8'h80);
        chk("primary_event_status", pes, 8'h80);
        sec_status = 8'h00;
        i_host.rd(8'h41, 8'h00);
        repeat (3) @(negedge clk);
        results;
    end
endmodule
